// >>> logic/sbc_regs_consts.svh
// offsets, field positions, reset values and timing counts of the control bank
`ifndef SBC_REGS_CONSTS_SVH
`define SBC_REGS_CONSTS_SVH

`define ADDR_MODE_SUPPLY 7'h01
`define ADDR_HW_CTRL0 7'h02
`define ADDR_WATCHDOG_CONTROL 7'h03
`define ADDR_WAKE_DATA1 7'h32
`define ADDR_WAKE_DATA0 7'h33
`define ADDR_FLEX_RATE 7'h34
`define ADDR_OSC_TRIM 7'h38
`define ADDR_SWK_OPT 7'h39
`define ADDR_OSC_CAL_H 7'h3A
`define ADDR_OSC_CAL_L 7'h3B
`define ADDR_CDR_CTRL1 7'h3C
`define ADDR_CDR_CTRL2 7'h3D
`define ADDR_CDR_LIM_H 7'h3E
`define ADDR_CDR_LIM_L 7'h3F

`define MS_MODE_HI 7
`define MS_MODE_LO 6
`define MS_AUX_HI 4
`define MS_AUX_LO 3
`define MS_OV_BIT 2
`define MS_LOW5_MASK 8'h1F
`define MS_WRITE_MASK 8'hDF
`define HW0_SRST_BIT 6
`define HW0_FO_BIT 5
`define HW0_CP_BIT 2
`define HW0_TOL_BIT 0
`define HW0_WRITE_MASK 8'h65
`define WD_WRITE_MASK 8'hF7

`define MS_RESET 8'h00
`define MS_DEV_RESET 8'h18
`define HW0_RESET 8'h00
`define WD_RESET 8'h14
`define GEN_RESET 8'h00

`define SOFT_RST_PULSE_NS 1000
`define CLK_PERIOD_NS 100
`define SOFT_RST_CYCLES ((`SOFT_RST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> logic/sbc_regs_pkg.sv
// types shared by the control bank
`default_nettype none
package sbc_regs_pkg;
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'h0,
		MODE_SLEEP = 2'h1,
		MODE_STOP = 2'h2,
		MODE_SOFT_RESET = 2'h3
	} op_mode_t;
	typedef enum logic [1:0] {
		AUX_OFF = 2'h0,
		AUX_ON_NORMAL = 2'h1,
		AUX_ON_NORMAL_STOP = 2'h2,
		AUX_ALWAYS_ON = 2'h3
	} aux_mode_t;
	typedef enum logic [1:0] {
		SPI_IDLE = 2'h0,
		SPI_ADDR = 2'h1,
		SPI_DATA = 2'h2
	} spi_state_t;
endpackage
`default_nettype wire

// >>> logic/spi_frame_slave.sv
// spi slave framing: address byte then data byte, msb first, mode 0
`include "sbc_regs_consts.svh"
`default_nettype none
module spi_frame_slave (
	// system
	input wire logic clk,
	input wire logic rst_n,
	// pins
	input wire logic spi_clk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	// register side
	output logic [6:0] reg_addr,
	output logic addr_valid,
	output logic wr_en,
	output logic [7:0] wr_data,
	input wire logic [7:0] rd_data,
	output logic frame_busy
);
	logic [2:0] sclk_sync_ff;
	logic [1:0] cs_sync_ff;
	logic [1:0] mosi_sync_ff;
	logic [7:0] shift_ff;
	logic [7:0] tx_ff;
	logic [3:0] bit_cnt_ff;
	logic wr_req_ff;
	logic [6:0] addr_ff;
	logic addr_valid_ff;
	logic wr_en_ff;
	logic adv_ff;
	logic [7:0] wr_data_ff;
	logic miso_ff;
	sbc_regs_pkg::spi_state_t state_ff;
	logic rise;
	logic fall;
	logic cs_act;
	logic [7:0] shifted;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclk_sync_ff <= 3'h0;
			cs_sync_ff <= 2'h3;
			mosi_sync_ff <= 2'h0;
		end else begin
			sclk_sync_ff <= {sclk_sync_ff[1:0], spi_clk};
			cs_sync_ff <= {cs_sync_ff[0], spi_cs_n};
			mosi_sync_ff <= {mosi_sync_ff[0], spi_mosi};
		end
	end

	// edge detection reads only the second and third stages
	assign rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];
	assign fall = ~sclk_sync_ff[1] & sclk_sync_ff[2];
	assign cs_act = ~cs_sync_ff[1];
	assign shifted = {shift_ff[6:0], mosi_sync_ff[1]};

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		addr_valid_ff <= 1'b0;
		wr_en_ff <= 1'b0;
		adv_ff <= 1'b0;
		if (!rst_n) begin
			state_ff <= sbc_regs_pkg::SPI_IDLE;
			shift_ff <= 8'h00;
			bit_cnt_ff <= 4'h0;
			wr_req_ff <= 1'b0;
			addr_ff <= 7'h00;
			wr_data_ff <= 8'h00;
		end else if (!cs_act) begin
			state_ff <= sbc_regs_pkg::SPI_IDLE;
			bit_cnt_ff <= 4'h0;
		end else begin
			// step on only after the write strobe has used the old address
			if (adv_ff) begin
				addr_ff <= addr_ff + 7'h01;
				addr_valid_ff <= 1'b1;
			end
			case (state_ff)
				sbc_regs_pkg::SPI_IDLE: begin
					state_ff <= sbc_regs_pkg::SPI_ADDR;
					bit_cnt_ff <= 4'h0;
				end
				sbc_regs_pkg::SPI_ADDR: begin
					if (rise) begin
						shift_ff <= shifted;
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
						if (bit_cnt_ff == 4'h7) begin
							// address in the top seven bits, access kind in the lowest
							addr_ff <= shifted[7:1];
							wr_req_ff <= shifted[0];
							addr_valid_ff <= 1'b1;
							bit_cnt_ff <= 4'h0;
							state_ff <= sbc_regs_pkg::SPI_DATA;
						end
					end
				end
				sbc_regs_pkg::SPI_DATA: begin
					if (rise) begin
						shift_ff <= shifted;
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
						if (bit_cnt_ff == 4'h7) begin
							wr_data_ff <= shifted;
							wr_en_ff <= wr_req_ff;
							// longer frames move on to the next address
							adv_ff <= 1'b1;
							bit_cnt_ff <= 4'h0;
						end
					end
				end
				default: state_ff <= sbc_regs_pkg::SPI_IDLE;
			endcase
		end
	end

	// the old value is loaded at the address strobe, before any write lands
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_ff <= 8'h00;
			miso_ff <= 1'b0;
		end else if (addr_valid_ff) begin
			tx_ff <= rd_data;
		end else if (cs_act && fall && state_ff == sbc_regs_pkg::SPI_DATA) begin
			miso_ff <= tx_ff[7];
			tx_ff <= {tx_ff[6:0], 1'b0};
		end
	end

	assign spi_miso = miso_ff;
	assign reg_addr = addr_ff;
	assign addr_valid = addr_valid_ff;
	assign wr_en = wr_en_ff;
	assign wr_data = wr_data_ff;
	assign frame_busy = cs_act;
endmodule
`default_nettype wire

// >>> logic/reset_pulse_gen.sv
// stretches a soft reset request into a low pulse on the reset output
`include "sbc_regs_consts.svh"
`default_nettype none
module reset_pulse_gen #(
	parameter int PULSE_CYCLES = `SOFT_RST_CYCLES
) (
	// system
	input wire logic clk,
	input wire logic rst_n,
	// request
	input wire logic trigger,
	// pin
	output logic reset_output_n
);
	logic [15:0] cnt_ff;
	logic out_n_ff;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_ff <= 16'h0000;
			out_n_ff <= 1'b0;
		end else if (trigger) begin
			cnt_ff <= 16'(PULSE_CYCLES);
			out_n_ff <= 1'b0;
		end else if (cnt_ff != 16'h0000) begin
			cnt_ff <= cnt_ff - 16'h0001;
			out_n_ff <= (cnt_ff == 16'h0001);
		end else begin
			out_n_ff <= 1'b1;
		end
	end

	assign reset_output_n = out_n_ff;
endmodule
`default_nettype wire

// >>> logic/sbc_mode_supply_control_regs.sv
// mode, supply and hardware control register bank behind the spi port
//
// Function
// - mode bits 7:6 pick normal, sleep, stop; 11 runs a soft reset
// - a write asking stop to sleep never enters sleep
// - stop to normal write ignores bits 4:0, flags error, still goes normal
// - entering restart rewrites the mode field to normal
// - restart entry or overtemperature forces the aux supply field off
// - aux supply field bits 4:3 select off, normal, normal+stop, always on
// - bit 2 chooses whether main overvoltage leads to restart or only sets the overvoltage flag
// - serial output on a write shows the value held before it
// - development mode resets aux supply to 11; soft reset then turns it off
// - soft reset pulses the reset output low unless bit 6 is set; lockable
// - bit 5 forces the fail output on when the pin is a fail output
// - clearing bit 5 leaves a failure-driven fail output on until flag clears
// - restart entry clears bit 5 and drops fail output unless failure holds it
// - bit 2 enables the charge pump; lockable
// - bit 0 set means restart after the first watchdog failure, else second
// - soft reset keeps pulse bit under lock b, charge pump under lock a
// - reserved bits read zero
// - soft reset clears mode and hw control except locked bits, reloads watchdog control; storage bank keeps its values
`include "sbc_regs_consts.svh"
`default_nettype none
module sbc_mode_supply_control_regs #(
	parameter int PULSE_CYCLES = `SOFT_RST_CYCLES
) (
	// system
	input wire logic clk,
	input wire logic rst_n,
	// spi pins
	input wire logic spi_clk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	// chip state and events
	input wire logic dev_mode_pin,
	input wire logic restart_entry,
	input wire logic overtemp_event,
	input wire logic main_overvoltage,
	input wire logic watchdog_trigger_fail,
	input wire logic failure_flag,
	input wire logic gpio_is_fail_output,
	input wire logic cfg_lock_a,
	input wire logic cfg_lock_b,
	input wire logic [7:0] osc_cal_high,
	input wire logic [7:0] osc_cal_low,
	// control outputs
	output logic [1:0] op_mode,
	output logic [1:0] aux_supply_mode,
	output logic [1:0] main_supply_reset_threshold,
	output logic main_overvoltage_flag,
	output logic restart_request,
	output logic access_error,
	output logic fail_output,
	output logic charge_pump_enable,
	output logic reset_output_n
);
	logic [6:0] reg_addr;
	logic addr_valid;
	logic wr_en;
	logic [7:0] wr_data;
	logic frame_busy;
	logic [7:0] rd_mux;
	logic [7:0] ms_ff;
	logic [7:0] hw0_ff;
	logic [7:0] wd_ff;
	logic [7:0] gen_ff [0:9];
	logic dev_mode_s1_ff;
	logic dev_mode_ff;
	logic [1:0] ev_sync1_ff;
	logic [1:0] ev_sync2_ff;
	logic [1:0] ev_last_ff;
	logic restart_ev;
	logic ot_ev;
	logic [5:0] lvl_s1_ff;
	logic [5:0] lvl_ff;
	logic ov_in;
	logic wdf_in;
	logic fail_in;
	logic gpio_fo;
	logic lock_a;
	logic lock_b;
	logic wdf_last_ff;
	logic ov_last_ff;
	logic [1:0] wdf_cnt_ff;
	logic soft_reset;
	logic ov_flag_ff;
	logic restart_req_ff;
	logic access_err_ff;
	logic fo_ff;
	logic cp_ff;
	logic [1:0] mode_out_ff;
	logic [1:0] aux_out_ff;
	logic [1:0] rt_out_ff;
	logic ms_wr;
	logic hw0_wr;
	logic [1:0] req_mode;
	logic [1:0] cur_mode;
	logic [7:0] aux_reset_val;

	////////////////////////////////////////////////////////////////////////
	spi_frame_slave u_spi (
		.clk(clk),
		.rst_n(rst_n),
		.spi_clk(spi_clk),
		.spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi),
		.spi_miso(spi_miso),
		.reg_addr(reg_addr),
		.addr_valid(addr_valid),
		.wr_en(wr_en),
		.wr_data(wr_data),
		.rd_data(rd_mux),
		.frame_busy(frame_busy)
	);

	reset_pulse_gen #(
		.PULSE_CYCLES(PULSE_CYCLES)
	) u_rst (
		.clk(clk),
		.rst_n(rst_n),
		.trigger(soft_reset & ~hw0_ff[`HW0_SRST_BIT]),
		.reset_output_n(reset_output_n)
	);

	////////////////////////////////////////////////////////////////////////
	// chip-side inputs except the oscillator calibration bytes come from other logic domains: two stages each
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ev_sync1_ff <= 2'h0;
			ev_sync2_ff <= 2'h0;
			ev_last_ff <= 2'h0;
			lvl_s1_ff <= 6'h00;
			lvl_ff <= 6'h00;
		end else begin
			ev_sync1_ff <= {overtemp_event, restart_entry};
			ev_sync2_ff <= ev_sync1_ff;
			ev_last_ff <= ev_sync2_ff;
			lvl_s1_ff <= {cfg_lock_b, cfg_lock_a, gpio_is_fail_output, failure_flag,
				watchdog_trigger_fail, main_overvoltage};
			lvl_ff <= lvl_s1_ff;
		end
	end

	assign restart_ev = ev_sync2_ff[0] & ~ev_last_ff[0];
	assign ot_ev = ev_sync2_ff[1] & ~ev_last_ff[1];
	assign ov_in = lvl_ff[0];
	assign wdf_in = lvl_ff[1];
	assign fail_in = lvl_ff[2];
	assign gpio_fo = lvl_ff[3];
	assign lock_a = lvl_ff[4];
	assign lock_b = lvl_ff[5];

	////////////////////////////////////////////////////////////////////////
	assign ms_wr = wr_en && reg_addr == `ADDR_MODE_SUPPLY;
	assign hw0_wr = wr_en && reg_addr == `ADDR_HW_CTRL0;
	assign req_mode = wr_data[`MS_MODE_HI:`MS_MODE_LO];
	assign cur_mode = ms_ff[`MS_MODE_HI:`MS_MODE_LO];
	assign soft_reset = ms_wr && req_mode == sbc_regs_pkg::MODE_SOFT_RESET;
	// development mode keeps the aux supply up through init; soft reset switches it off
	assign aux_reset_val = dev_mode_ff ? `MS_DEV_RESET : `MS_RESET;

	// mode and supply control
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ms_ff <= aux_reset_val;
			access_err_ff <= 1'b0;
		end else begin
			if (soft_reset) begin
				ms_ff <= `MS_RESET;
			end else if (ms_wr) begin
				if (cur_mode == sbc_regs_pkg::MODE_STOP &&
					req_mode == sbc_regs_pkg::MODE_SLEEP) begin
					ms_ff <= ms_ff;
				end else if (cur_mode == sbc_regs_pkg::MODE_STOP &&
					req_mode == sbc_regs_pkg::MODE_NORMAL) begin
					ms_ff <= {req_mode, ms_ff[5:0]};
					access_err_ff <= 1'b1;
				end else begin
					ms_ff <= wr_data & `MS_WRITE_MASK;
				end
			end
			if (restart_ev) begin
				ms_ff[`MS_MODE_HI:`MS_MODE_LO] <= sbc_regs_pkg::MODE_NORMAL;
			end
			if (restart_ev || ot_ev) begin
				ms_ff[`MS_AUX_HI:`MS_AUX_LO] <= sbc_regs_pkg::AUX_OFF;
			end
			if (reg_addr == `ADDR_MODE_SUPPLY && addr_valid && !wr_en && frame_busy
				&& !(ms_wr && cur_mode == sbc_regs_pkg::MODE_STOP)) begin
				access_err_ff <= 1'b0;
			end
		end
	end

	// no reset here, so the pin level is already known when reset lets go
	always_ff @(posedge clk) begin
		dev_mode_s1_ff <= dev_mode_pin;
		dev_mode_ff <= dev_mode_s1_ff;
	end

	// hardware control 0, with lock-aware soft reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hw0_ff <= `HW0_RESET;
		end else begin
			if (soft_reset) begin
				if (!lock_b) begin
					hw0_ff[`HW0_SRST_BIT] <= 1'b0;
				end
				if (!lock_a) begin
					hw0_ff[`HW0_CP_BIT] <= 1'b0;
				end
				hw0_ff[`HW0_FO_BIT] <= 1'b0;
				hw0_ff[`HW0_TOL_BIT] <= 1'b0;
			end else if (hw0_wr) begin
				hw0_ff[`HW0_FO_BIT] <= wr_data[`HW0_FO_BIT];
				hw0_ff[`HW0_TOL_BIT] <= wr_data[`HW0_TOL_BIT];
				if (!lock_b) begin
					hw0_ff[`HW0_SRST_BIT] <= wr_data[`HW0_SRST_BIT];
				end
				if (!lock_a) begin
					hw0_ff[`HW0_CP_BIT] <= wr_data[`HW0_CP_BIT];
				end
			end
			if (restart_ev) begin
				hw0_ff[`HW0_FO_BIT] <= 1'b0;
			end
			hw0_ff[7] <= 1'b0;
			hw0_ff[4:3] <= 2'h0;
			hw0_ff[1] <= 1'b0;
		end
	end

	// watchdog control and the wake/clock-recovery storage bank
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wd_ff <= `WD_RESET;
			for (int i = 0; i < 10; i++) begin
				gen_ff[i] <= `GEN_RESET;
			end
		end else if (soft_reset) begin
			wd_ff <= `WD_RESET;
		end else if (wr_en) begin
			if (reg_addr == `ADDR_WATCHDOG_CONTROL) begin
				wd_ff <= wr_data & `WD_WRITE_MASK;
			end else if (reg_addr >= `ADDR_WAKE_DATA1 && reg_addr <= `ADDR_FLEX_RATE) begin
				gen_ff[3'(reg_addr - `ADDR_WAKE_DATA1)] <= wr_data;
			end else if (reg_addr == `ADDR_OSC_TRIM || reg_addr == `ADDR_SWK_OPT) begin
				gen_ff[4'(reg_addr - `ADDR_OSC_TRIM) + 4'h3] <= wr_data;
			end else if (reg_addr >= `ADDR_CDR_CTRL1 && reg_addr <= `ADDR_CDR_LIM_L) begin
				gen_ff[4'(reg_addr - `ADDR_CDR_CTRL1) + 4'h5] <= wr_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// overvoltage flag always latches; restart follows only with bit 2 set
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ov_flag_ff <= 1'b0;
			restart_req_ff <= 1'b0;
			wdf_last_ff <= 1'b0;
			ov_last_ff <= 1'b0;
			wdf_cnt_ff <= 2'h0;
		end else begin
			wdf_last_ff <= wdf_in;
			ov_last_ff <= ov_in;
			restart_req_ff <= 1'b0;
			if (ov_in) begin
				ov_flag_ff <= 1'b1;
				// a held overvoltage asks for one restart, not one per cycle
				restart_req_ff <= ms_ff[`MS_OV_BIT] & ~ov_last_ff;
			end else if (ms_wr && !soft_reset) begin
				ov_flag_ff <= 1'b0;
			end
			if (restart_ev) begin
				wdf_cnt_ff <= 2'h0;
			end else if (wdf_in && !wdf_last_ff) begin
				if (hw0_ff[`HW0_TOL_BIT] || wdf_cnt_ff != 2'h0) begin
					restart_req_ff <= 1'b1;
					wdf_cnt_ff <= 2'h0;
				end else begin
					wdf_cnt_ff <= 2'h1;
				end
			end
		end
	end

	// outputs straight from flip-flops
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fo_ff <= 1'b0;
			cp_ff <= 1'b0;
			mode_out_ff <= 2'h0;
			aux_out_ff <= 2'h0;
			rt_out_ff <= 2'h0;
		end else begin
			// failure keeps the output up whatever software does
			fo_ff <= fail_in | (hw0_ff[`HW0_FO_BIT] & gpio_fo & ~restart_ev);
			cp_ff <= hw0_ff[`HW0_CP_BIT];
			mode_out_ff <= (cur_mode == sbc_regs_pkg::MODE_SOFT_RESET) ?
				2'(sbc_regs_pkg::MODE_NORMAL) : cur_mode;
			aux_out_ff <= ms_ff[`MS_AUX_HI:`MS_AUX_LO];
			rt_out_ff <= ms_ff[1:0];
		end
	end

	// read data sampled once per address; reserved bits held at zero
	always_comb begin
		rd_mux = 8'h00;
		if (reg_addr == `ADDR_MODE_SUPPLY) begin
			rd_mux = ms_ff & `MS_WRITE_MASK;
		end else if (reg_addr == `ADDR_HW_CTRL0) begin
			rd_mux = hw0_ff & `HW0_WRITE_MASK;
		end else if (reg_addr == `ADDR_WATCHDOG_CONTROL) begin
			rd_mux = wd_ff & `WD_WRITE_MASK;
		end else if (reg_addr >= `ADDR_WAKE_DATA1 && reg_addr <= `ADDR_FLEX_RATE) begin
			rd_mux = gen_ff[3'(reg_addr - `ADDR_WAKE_DATA1)];
		end else if (reg_addr == `ADDR_OSC_TRIM || reg_addr == `ADDR_SWK_OPT) begin
			rd_mux = gen_ff[4'(reg_addr - `ADDR_OSC_TRIM) + 4'h3];
		end else if (reg_addr == `ADDR_OSC_CAL_H) begin
			rd_mux = osc_cal_high;
		end else if (reg_addr == `ADDR_OSC_CAL_L) begin
			rd_mux = osc_cal_low;
		end else if (reg_addr >= `ADDR_CDR_CTRL1 && reg_addr <= `ADDR_CDR_LIM_L) begin
			rd_mux = gen_ff[4'(reg_addr - `ADDR_CDR_CTRL1) + 4'h5];
		end
	end

	assign op_mode = mode_out_ff;
	assign aux_supply_mode = aux_out_ff;
	assign main_supply_reset_threshold = rt_out_ff;
	assign main_overvoltage_flag = ov_flag_ff;
	assign restart_request = restart_req_ff;
	assign access_error = access_err_ff;
	assign fail_output = fo_ff;
	assign charge_pump_enable = cp_ff;
endmodule
`default_nettype wire

// >>> test/sbc_spi_master_model.sv
// spi master model standing in for the microcontroller
`default_nettype none
module sbc_spi_master_model (
	// system
	input wire logic clk,
	// spi pins
	output logic spi_clk,
	output logic spi_cs_n,
	output logic spi_mosi,
	input wire logic spi_miso
);
	timeunit 1ns;
	timeprecision 1ns;
	// half period well above the 3 clk the slave needs
	localparam int HALF = 8;
	initial begin
		spi_clk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#10;
	endtask
	task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d,
		output logic [7:0] q);
		logic [15:0] sh;
		sh = {a, w, d};
		q = 8'h00;
		spi_cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			spi_mosi = sh[i];
			tick(HALF);
			spi_clk = 1'b1;
			if (i < 8) begin
				q = {q[6:0], spi_miso};
			end
			tick(HALF);
			spi_clk = 1'b0;
		end
		spi_cs_n = 1'b1;
		// released line carries no stale data
		spi_mosi = ~spi_mosi;
		tick(HALF);
	endtask
endmodule
`default_nettype wire

// >>> test/sbc_mode_supply_control_regs_assertions.sv
// port checker for the mode and hardware control bank
`default_nettype none
module sbc_mode_supply_control_regs_assertions #(
	parameter int PULSE_CYCLES = 10
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic dev_mode_pin,
	input wire logic restart_entry,
	input wire logic overtemp_event,
	input wire logic main_overvoltage,
	input wire logic failure_flag,
	input wire logic gpio_is_fail_output,
	input wire logic [1:0] op_mode,
	input wire logic [1:0] aux_supply_mode,
	input wire logic main_overvoltage_flag,
	input wire logic restart_request,
	input wire logic fail_output,
	input wire logic reset_output_n
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////
	int low_cnt;
	always_ff @(posedge clk) begin
		if (!rst_n || reset_output_n) begin
			low_cnt <= 0;
		end else begin
			low_cnt <= low_cnt + 1;
		end
	end
	sequence s_restart;
		$rose(restart_entry);
	endsequence
	sequence s_go_normal;
		##[1:6] op_mode == 2'h0;
	endsequence
	property p_no_mode11;
		op_mode != 2'h3;
	endproperty
	a_no_mode11: assert property (p_no_mode11) else $error("mode output shows 11");
	property p_stop_no_sleep;
		$past(op_mode) == 2'h2 |-> op_mode != 2'h1;
	endproperty
	a_stop_no_sleep: assert property (p_stop_no_sleep) else $error("stop went to sleep");
	property p_restart_normal;
		s_restart |-> s_go_normal;
	endproperty
	a_restart_normal: assert property (p_restart_normal) else $error("mode not normal");
	property p_restart_aux;
		$rose(restart_entry) && !dev_mode_pin |-> ##[1:6] aux_supply_mode == 2'h0;
	endproperty
	a_restart_aux: assert property (p_restart_aux) else $error("aux on after restart");
	property p_ot_aux;
		$rose(overtemp_event) && !dev_mode_pin |-> ##[1:6] aux_supply_mode == 2'h0;
	endproperty
	a_ot_aux: assert property (p_ot_aux) else $error("aux on after overtemp");
	property p_restart_fo;
		$rose(restart_entry) && !failure_flag |-> ##[1:6] !fail_output;
	endproperty
	a_restart_fo: assert property (p_restart_fo) else $error("fail output kept");
	property p_failure_fo;
		(failure_flag && gpio_is_fail_output) [*5] |-> fail_output;
	endproperty
	a_failure_fo: assert property (p_failure_fo) else $error("failure not shown");
	property p_fo_pin;
		(!gpio_is_fail_output) [*5] |-> !fail_output;
	endproperty
	a_fo_pin: assert property (p_fo_pin) else $error("fail output without pin");
	property p_ov_flag;
		$rose(main_overvoltage) |-> ##[1:6] main_overvoltage_flag;
	endproperty
	a_ov_flag: assert property (p_ov_flag) else $error("overvoltage flag missing");
	property p_req_single;
		restart_request |=> !restart_request;
	endproperty
	a_req_single: assert property (p_req_single) else $error("restart request too long");
	property p_pulse_len;
		low_cnt <= PULSE_CYCLES + 4;
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("reset output low too long");
endmodule
bind sbc_mode_supply_control_regs sbc_mode_supply_control_regs_assertions #(
	.PULSE_CYCLES(PULSE_CYCLES)) u_chk (.clk(clk), .rst_n(rst_n),
	.dev_mode_pin(dev_mode_pin), .restart_entry(restart_entry),
	.overtemp_event(overtemp_event), .main_overvoltage(main_overvoltage),
	.failure_flag(failure_flag), .gpio_is_fail_output(gpio_is_fail_output),
	.op_mode(op_mode), .aux_supply_mode(aux_supply_mode),
	.main_overvoltage_flag(main_overvoltage_flag), .restart_request(restart_request),
	.fail_output(fail_output), .reset_output_n(reset_output_n));
`default_nettype wire

// >>> test/sbc_mode_supply_control_regs_tb_top.sv
// testbench for the mode and hardware control bank
`include "sbc_regs_consts.svh"
`default_nettype none
module sbc_mode_supply_control_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// short soft reset pulse keeps the run brief
	localparam int PULSE = 3;
	logic clk, rst_n, spi_clk, spi_cs_n, spi_mosi, spi_miso, dev_mode_pin;
	logic restart_entry, overtemp_event, main_overvoltage, watchdog_trigger_fail;
	logic failure_flag, gpio_is_fail_output, cfg_lock_a, cfg_lock_b, access_error;
	logic [1:0] op_mode, aux_supply_mode, main_supply_reset_threshold;
	logic main_overvoltage_flag, restart_request, fail_output, charge_pump_enable;
	logic reset_output_n;
	logic [7:0] rd;
	int n_fail = 0;
	int check_count = 0;
	int cycles = 0;
	int req_cnt = 0;
	int rst_low = 0;
	sbc_mode_supply_control_regs #(.PULSE_CYCLES(PULSE)) uut (.clk(clk), .rst_n(rst_n),
		.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
		.dev_mode_pin(dev_mode_pin), .restart_entry(restart_entry),
		.overtemp_event(overtemp_event), .main_overvoltage(main_overvoltage),
		.watchdog_trigger_fail(watchdog_trigger_fail), .failure_flag(failure_flag),
		.gpio_is_fail_output(gpio_is_fail_output), .cfg_lock_a(cfg_lock_a),
		.cfg_lock_b(cfg_lock_b), .osc_cal_high(8'hA5), .osc_cal_low(8'h5A),
		.op_mode(op_mode), .aux_supply_mode(aux_supply_mode),
		.main_supply_reset_threshold(main_supply_reset_threshold),
		.main_overvoltage_flag(main_overvoltage_flag), .restart_request(restart_request),
		.access_error(access_error), .fail_output(fail_output),
		.charge_pump_enable(charge_pump_enable), .reset_output_n(reset_output_n));
	sbc_spi_master_model mst (.clk(clk), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi), .spi_miso(spi_miso));
	////////////////////////////////////////////////////////////////
	initial clk = 1'b0;
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (restart_request === 1'b1) req_cnt++;
		if (rst_n === 1'b1 && reset_output_n === 1'b0) rst_low++;
		if (cycles == 40000) begin
			n_fail++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#10;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t ns got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		mst.xfer(a, 1'b1, d, rd);
	endtask
	task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
		mst.xfer(a, 1'b0, 8'h00, rd);
		chk(rd, exp);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		step(4);
		s = 1'b0;
		step(8);
	endtask
	task automatic soft_rst();
		rst_low = 0;
		wr(`ADDR_MODE_SUPPLY, 8'hC0);
		step(40);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{rst_n, dev_mode_pin, restart_entry, overtemp_event, main_overvoltage} = 5'h00;
		{watchdog_trigger_fail, failure_flag, cfg_lock_a, cfg_lock_b} = 4'h0;
		gpio_is_fail_output = 1'b1;
		step(16);
		rst_n = 1'b1;
		step(8);
		rdc(`ADDR_MODE_SUPPLY, `MS_RESET);
		rdc(`ADDR_HW_CTRL0, `HW0_RESET);
		rdc(`ADDR_WATCHDOG_CONTROL, `WD_RESET);
		rdc(7'h05, 8'h00);
		rdc(`ADDR_OSC_CAL_H, 8'hA5);
		rdc(`ADDR_OSC_CAL_L, 8'h5A);
		$display("test reset_map done");
		for (int i = 0; i < 4; i++) begin
			wr(`ADDR_MODE_SUPPLY, 8'(i << 3));
			chk(rd, 8'((i == 0 ? 0 : i - 1) << 3));
			chk({6'h00, aux_supply_mode}, 8'(i));
		end
		wr(`ADDR_MODE_SUPPLY, 8'h3E);
		chk(rd, 8'h18);
		rdc(`ADDR_MODE_SUPPLY, 8'h1E);
		chk({6'h00, main_supply_reset_threshold}, 8'h02);
		$display("test mode_fields done");
		wr(`ADDR_MODE_SUPPLY, 8'h80);
		chk({6'h00, op_mode}, 8'h02);
		wr(`ADDR_MODE_SUPPLY, 8'h40);
		chk({6'h00, op_mode}, 8'h02);
		wr(`ADDR_MODE_SUPPLY, 8'h1F);
		chk({6'h00, op_mode}, 8'h00);
		chk({7'h00, access_error}, 8'h01);
		rdc(`ADDR_MODE_SUPPLY, 8'h00);
		chk({7'h00, access_error}, 8'h00);
		$display("test transitions done");
		wr(`ADDR_HW_CTRL0, 8'hFF);
		rdc(`ADDR_HW_CTRL0, 8'h65);
		chk({7'h00, charge_pump_enable}, 8'h01);
		chk({7'h00, fail_output}, 8'h01);
		gpio_is_fail_output = 1'b0;
		step(6);
		chk({7'h00, fail_output}, 8'h00);
		gpio_is_fail_output = 1'b1;
		wr(`ADDR_HW_CTRL0, 8'h00);
		chk({6'h00, charge_pump_enable, fail_output}, 8'h00);
		{cfg_lock_a, cfg_lock_b} = 2'h3;
		wr(`ADDR_HW_CTRL0, 8'h44);
		rdc(`ADDR_HW_CTRL0, 8'h00);
		{cfg_lock_a, cfg_lock_b} = 2'h0;
		wr(`ADDR_HW_CTRL0, 8'h44);
		{cfg_lock_a, cfg_lock_b} = 2'h3;
		soft_rst();
		chk(8'(rst_low), 8'h00);
		rdc(`ADDR_HW_CTRL0, 8'h44);
		rdc(`ADDR_MODE_SUPPLY, 8'h00);
		cfg_lock_b = 1'b0;
		wr(`ADDR_HW_CTRL0, 8'h04);
		soft_rst();
		chk({7'h00, rst_low >= PULSE}, 8'h01);
		rdc(`ADDR_HW_CTRL0, 8'h04);
		cfg_lock_a = 1'b0;
		soft_rst();
		rdc(`ADDR_HW_CTRL0, 8'h00);
		$display("test hw_control done");
		failure_flag = 1'b1;
		wr(`ADDR_HW_CTRL0, 8'h20);
		wr(`ADDR_HW_CTRL0, 8'h00);
		chk({7'h00, fail_output}, 8'h01);
		failure_flag = 1'b0;
		step(6);
		chk({7'h00, fail_output}, 8'h00);
		wr(`ADDR_HW_CTRL0, 8'h20);
		wr(`ADDR_MODE_SUPPLY, 8'h88);
		pulse(restart_entry);
		chk({7'h00, fail_output}, 8'h00);
		rdc(`ADDR_HW_CTRL0, 8'h00);
		rdc(`ADDR_MODE_SUPPLY, 8'h00);
		wr(`ADDR_MODE_SUPPLY, 8'h10);
		pulse(overtemp_event);
		chk({6'h00, aux_supply_mode}, 8'h00);
		$display("test restart done");
		req_cnt = 0;
		pulse(main_overvoltage);
		chk({7'h00, main_overvoltage_flag}, 8'h01);
		chk(8'(req_cnt), 8'h00);
		wr(`ADDR_MODE_SUPPLY, 8'h04);
		pulse(main_overvoltage);
		chk({7'h00, main_overvoltage_flag}, 8'h01);
		chk(8'(req_cnt), 8'h01);
		wr(`ADDR_MODE_SUPPLY, 8'h00);
		req_cnt = 0;
		pulse(watchdog_trigger_fail);
		chk(8'(req_cnt), 8'h00);
		pulse(watchdog_trigger_fail);
		chk(8'(req_cnt), 8'h01);
		wr(`ADDR_HW_CTRL0, 8'h01);
		pulse(watchdog_trigger_fail);
		chk(8'(req_cnt), 8'h02);
		$display("test events done");
		dev_mode_pin = 1'b1;
		rst_n = 1'b0;
		step(16);
		rst_n = 1'b1;
		step(8);
		chk({6'h00, aux_supply_mode}, 8'h03);
		rdc(`ADDR_MODE_SUPPLY, 8'h18);
		soft_rst();
		chk({6'h00, aux_supply_mode}, 8'h00);
		$display("test dev_reset done");
		summarize();
	end
endmodule
`default_nettype wire
